/* design/dtm_pkg.sv */
// package: register map, field positions and reset values of the dual timer
package dtm_pkg;
  // register byte addresses (word index times four)
  localparam logic [7:0] ADDR_MODE = 8'h89; // timer_mode_reg offset
  localparam logic [9:0] BYTE_MODE = 10'h0_224; // 0x89 * 4
  localparam logic [9:0] BYTE_CTRL = 10'h0_000; // timer_control_reg
  localparam logic [9:0] BYTE_CLK = 10'h0_004; // clock_control_reg
  localparam logic [9:0] BYTE_IRQCFG = 10'h0_008; // ext_irq_config_reg
  localparam logic [9:0] BYTE_T0 = 10'h0_00C; // timer 0 count bytes
  localparam logic [9:0] BYTE_T1 = 10'h0_010; // timer 1 count bytes
  localparam logic [9:0] BYTE_STAT = 10'h0_014; // sticky status
  localparam logic [9:0] BYTE_MASK = 10'h0_018; // interrupt mask
  // mode register fields
  localparam int MODE_TMR1_GATE_SEL = 7;
  localparam int MODE_SRC1 = 6;
  localparam int MODE_M1_HI = 5;
  localparam int MODE_M1_LO = 4;
  localparam int MODE_TMR0_GATE_SEL = 3;
  localparam int MODE_SRC0 = 2;
  localparam int MODE_M0_HI = 1;
  localparam int MODE_M0_LO = 0;
  // control register fields
  localparam int CTRL_TF1 = 7;
  localparam int CTRL_TR1 = 6;
  localparam int CTRL_TF0 = 5;
  localparam int CTRL_TR0 = 4;
  // clock control fields
  localparam int CLK_T1SEL = 3;
  localparam int CLK_T0SEL = 2;
  // irq config fields
  localparam int IRQCFG_POL1 = 7;
  localparam int IRQCFG_POL0 = 3;
  // reset values
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CLK_RESET = 8'h00;
  localparam logic [7:0] IRQCFG_RESET = 8'h00;
  localparam logic [15:0] TMR_RESET = 16'h0000;
  localparam logic [1:0] STAT_RESET = 2'h0;
  localparam logic [1:0] MASK_RESET = 2'h0;
  // prescaler for the slow timer clock
  localparam int PRESCALE_DIV = 12;
  localparam logic [3:0] PRESCALE_LAST = 4'(PRESCALE_DIV - 1);
  // timer modes
  typedef enum logic [1:0] {
    MODE_13BIT = 2'b00,
    MODE_16BIT = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT = 2'b11
  } dtm_mode_t;
endpackage : dtm_pkg

/* design/dtm_timer.sv */
// dual 8051-style counter/timer with Avalon-MM register slave
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dtm_timer
  import dtm_pkg::*;
(
  input wire logic mclk, // 125 MHz clock
  input wire logic reset, // async, active high
  input wire logic clkEn, // freezes all state while low
  input wire logic [9:0] avsAddress, // byte address
  input wire logic avsRead, // read request
  input wire logic avsWrite, // write request
  input wire logic [31:0] avsWriteData, // write data
  input wire logic [3:0] avsByteEnable, // byte lanes
  output logic [31:0] avsReadData, // read data
  output logic avsWaitRequest, // stall
  output logic [1:0] avsResponse, // 00 ok, 10 slave error
  input wire logic ext_irq0_n, // timer 0 gate pin
  input wire logic ext_irq1_n, // timer 1 gate pin
  input wire logic tmr0_count_pin, // timer 0 count pin
  input wire logic tmr1_count_pin, // timer 1 count pin
  output logic irq // level interrupt
);
  // =====================================================
  // declarations
  logic [7:0] timer_mode_reg;
  logic [7:0] timer_control_reg;
  logic [7:0] clock_control_reg;
  logic [7:0] ext_irq_config_reg;
  logic [7:0] countLow_reg [2];
  logic [7:0] countHigh_reg [2];
  logic [1:0] status_reg;
  logic [1:0] mask_reg;
  logic [3:0] prescale_reg;
  logic ack_reg;
  logic [31:0] readData_reg;
  logic [1:0] resp_reg;
  logic [1:0] irqSync1_reg, irqSync2_reg;
  logic [1:0] pinSync1_reg, pinSync2_reg, pinSync3_reg;
  logic prescaleTick;
  logic [1:0] tick, overflow, setFlag;
  logic [1:0] runBit, gateBit, srcBit, clkSel, polBit;
  logic [7:0] nextLow [2];
  logic [7:0] nextHigh [2];
  logic wrAcc, rdAcc, hit;

  // byte-lane merge
  function automatic logic [7:0] laneMerge(input logic [7:0] old, input logic [31:0] wd, input logic [3:0] be,
                                           input int lane);
    laneMerge = be[lane] ? wd[lane*8 +: 8] : old;
  endfunction : laneMerge

  // known address decode
  function automatic logic addrKnown(input logic [9:0] a);
    addrKnown = (a == BYTE_MODE) || (a == BYTE_CTRL) || (a == BYTE_CLK) || (a == BYTE_IRQCFG) ||
                (a == BYTE_T0) || (a == BYTE_T1) || (a == BYTE_STAT) || (a == BYTE_MASK);
  endfunction : addrKnown

  // write strobe for one register word
  function automatic logic wrHit(input logic acc, input logic [9:0] a, input logic [9:0] target);
    wrHit = acc && (a == target);
  endfunction : wrHit

  // =====================================================
  // bus handshake: one wait cycle, then ack
  assign avsWaitRequest = (avsRead | avsWrite) & ~ack_reg;
  assign wrAcc = avsWrite & ack_reg & clkEn;
  assign rdAcc = avsRead & ~ack_reg & clkEn;
  assign hit = addrKnown(avsAddress);
  assign avsReadData = readData_reg;
  assign avsResponse = resp_reg;

  // ack pulse
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ack_reg <= 1'b0;
    end else if (clkEn) begin
      ack_reg <= (avsRead | avsWrite) & ~ack_reg;
    end
  end

  // read data capture, stands at the ack edge
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      readData_reg <= 32'h0000_0000;
      resp_reg <= 2'b00;
    end else if (clkEn && (avsRead | avsWrite) && !ack_reg) begin
      resp_reg <= hit ? 2'b00 : 2'b10;
      readData_reg <= 32'h0000_0000;
      if (rdAcc) begin
        case (avsAddress)
          BYTE_MODE: readData_reg <= {24'h00_0000, timer_mode_reg};
          BYTE_CTRL: readData_reg <= {24'h00_0000, timer_control_reg};
          BYTE_CLK: readData_reg <= {24'h00_0000, clock_control_reg};
          BYTE_IRQCFG: readData_reg <= {24'h00_0000, ext_irq_config_reg};
          BYTE_T0: readData_reg <= {16'h0000, countHigh_reg[0], countLow_reg[0]};
          BYTE_T1: readData_reg <= {16'h0000, countHigh_reg[1], countLow_reg[1]};
          BYTE_STAT: readData_reg <= {30'h0000_0000, status_reg};
          BYTE_MASK: readData_reg <= {30'h0000_0000, mask_reg};
          default: readData_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // =====================================================
  // pin synchronisers plus one stage for edge detect
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      irqSync1_reg <= 2'b11;
      irqSync2_reg <= 2'b11;
      pinSync1_reg <= 2'b11;
      pinSync2_reg <= 2'b11;
      pinSync3_reg <= 2'b11;
    end else if (clkEn) begin
      irqSync1_reg <= {ext_irq1_n, ext_irq0_n};
      irqSync2_reg <= irqSync1_reg;
      pinSync1_reg <= {tmr1_count_pin, tmr0_count_pin};
      pinSync2_reg <= pinSync1_reg;
      pinSync3_reg <= pinSync2_reg;
    end
  end

  // slow timer clock divider
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      prescale_reg <= 4'h0;
    end else if (clkEn) begin
      prescale_reg <= (prescale_reg == PRESCALE_LAST) ? 4'h0 : prescale_reg + 4'h1;
    end
  end
  assign prescaleTick = (prescale_reg == PRESCALE_LAST);

  // =====================================================
  // per-timer field pick
  assign runBit = {timer_control_reg[CTRL_TR1], timer_control_reg[CTRL_TR0]};
  assign gateBit = {timer_mode_reg[MODE_TMR1_GATE_SEL], timer_mode_reg[MODE_TMR0_GATE_SEL]};
  assign srcBit = {timer_mode_reg[MODE_SRC1], timer_mode_reg[MODE_SRC0]};
  assign clkSel = {clock_control_reg[CLK_T1SEL], clock_control_reg[CLK_T0SEL]};
  assign polBit = {ext_irq_config_reg[IRQCFG_POL1], ext_irq_config_reg[IRQCFG_POL0]};

  // count enable and next count per timer
  for (genvar t = 0; t < 2; t++) begin : gTimer
    logic pinActive, enable, srcTick;
    logic [1:0] modeField;
    logic [8:0] lowInc;
    logic [8:0] highInc;
    logic [5:0] lowInc5;
    assign modeField = (t == 0) ? timer_mode_reg[MODE_M0_HI:MODE_M0_LO] : timer_mode_reg[MODE_M1_HI:MODE_M1_LO];
    assign pinActive = (irqSync2_reg[t] == polBit[t]); // polarity 1 means active high
    assign enable = runBit[t] & (~gateBit[t] | pinActive);
    assign srcTick = srcBit[t] ? (pinSync3_reg[t] & ~pinSync2_reg[t])
                               : (clkSel[t] | prescaleTick);
    assign tick[t] = enable & srcTick & ~(t == 1 && modeField == MODE_SPLIT);
    assign lowInc = {1'b0, countLow_reg[t]} + 9'h001;
    assign lowInc5 = {1'b0, countLow_reg[t][4:0]} + 6'h01; // five low bits of the 13-bit count
    assign highInc = {1'b0, countHigh_reg[t]} + 9'h001;

    // mode decode: next bytes and overflow
    always_comb begin
      nextLow[t] = countLow_reg[t];
      nextHigh[t] = countHigh_reg[t];
      overflow[t] = 1'b0;
      if (tick[t]) begin
        case (dtm_mode_t'(modeField))
          MODE_13BIT: begin
            nextLow[t] = {3'b000, lowInc5[4:0]};
            if (lowInc5[5]) begin
              nextLow[t] = 8'h00;
              nextHigh[t] = highInc[7:0];
              overflow[t] = highInc[8];
            end
          end
          MODE_16BIT: begin
            nextLow[t] = lowInc[7:0];
            if (lowInc[8]) begin
              nextHigh[t] = highInc[7:0];
              overflow[t] = highInc[8];
            end
          end
          MODE_RELOAD: begin
            nextLow[t] = lowInc[8] ? countHigh_reg[t] : lowInc[7:0];
            nextHigh[t] = countHigh_reg[t];
            overflow[t] = lowInc[8];
          end
          MODE_SPLIT: begin
            nextLow[t] = lowInc[7:0];
            overflow[t] = lowInc[8];
          end
          default: begin
            nextLow[t] = countLow_reg[t];
          end
        endcase
      end
    end
  end

  // =====================================================
  // timer 0 in split mode lends its high byte to timer 1's run bit
  logic splitHighTick;
  logic [8:0] splitHighInc;
  assign splitHighTick = (timer_mode_reg[MODE_M0_HI:MODE_M0_LO] == MODE_SPLIT) & runBit[1] & prescaleTick;
  assign splitHighInc = {1'b0, countHigh_reg[0]} + 9'h001;
  assign setFlag[0] = overflow[0];
  assign setFlag[1] = overflow[1] | (splitHighTick & splitHighInc[8]);

  // =====================================================
  // count bytes: software write or hardware advance
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      countLow_reg[0] <= TMR_RESET[7:0];
      countHigh_reg[0] <= TMR_RESET[15:8];
      countLow_reg[1] <= TMR_RESET[7:0];
      countHigh_reg[1] <= TMR_RESET[15:8];
    end else if (clkEn) begin
      countLow_reg[0] <= nextLow[0];
      countHigh_reg[0] <= splitHighTick ? splitHighInc[7:0] : nextHigh[0];
      countLow_reg[1] <= nextLow[1];
      countHigh_reg[1] <= nextHigh[1];
      if (wrHit(wrAcc, avsAddress, BYTE_T0)) begin
        countLow_reg[0] <= laneMerge(countLow_reg[0], avsWriteData, avsByteEnable, 0);
        countHigh_reg[0] <= laneMerge(countHigh_reg[0], avsWriteData, avsByteEnable, 1);
      end
      if (wrHit(wrAcc, avsAddress, BYTE_T1)) begin
        countLow_reg[1] <= laneMerge(countLow_reg[1], avsWriteData, avsByteEnable, 0);
        countHigh_reg[1] <= laneMerge(countHigh_reg[1], avsWriteData, avsByteEnable, 1);
      end
    end
  end

  // =====================================================
  // configuration registers
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      timer_mode_reg <= MODE_RESET;
      clock_control_reg <= CLK_RESET;
      ext_irq_config_reg <= IRQCFG_RESET;
    end else if (wrAcc) begin
      if (avsAddress == BYTE_MODE) timer_mode_reg <= laneMerge(timer_mode_reg, avsWriteData, avsByteEnable, 0);
      if (avsAddress == BYTE_CLK) clock_control_reg <= laneMerge(clock_control_reg, avsWriteData, avsByteEnable, 0);
      if (avsAddress == BYTE_IRQCFG) begin
        ext_irq_config_reg <= laneMerge(ext_irq_config_reg, avsWriteData, avsByteEnable, 0);
      end
    end
  end

  // control register: overflow flags sticky, set wins over clear
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      timer_control_reg <= CTRL_RESET;
    end else if (clkEn) begin
      if (wrHit(wrAcc, avsAddress, BYTE_CTRL) && avsByteEnable[0]) begin
        timer_control_reg <= avsWriteData[7:0];
      end
      if (setFlag[0]) timer_control_reg[CTRL_TF0] <= 1'b1;
      if (setFlag[1]) timer_control_reg[CTRL_TF1] <= 1'b1;
    end
  end

  // =====================================================
  // interrupt registers
  // mask: written by software only
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mask_reg <= MASK_RESET;
    end else if (wrHit(wrAcc, avsAddress, BYTE_MASK) && avsByteEnable[0]) begin
      mask_reg <= avsWriteData[1:0];
    end
  end

  // interrupt status: sticky, write one to clear, set wins
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      status_reg <= STAT_RESET;
    end else if (clkEn) begin
      for (int i = 0; i < 2; i++) begin
        if (setFlag[i]) begin
          status_reg[i] <= 1'b1;
        end else if (wrHit(wrAcc, avsAddress, BYTE_STAT) && avsByteEnable[0] && avsWriteData[i]) begin
          status_reg[i] <= 1'b0;
        end
      end
    end
  end

  // level interrupt
  assign irq = |(status_reg & mask_reg);
endmodule : dtm_timer
`default_nettype wire

/* sim/dtm_timer_monitor.sv */
// checker: bus handshake, readback and interrupt masking of the dual timer
`timescale 1ns/1ps
`default_nettype none
module dtm_timer_monitor
  import dtm_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic reset, // async reset
  input wire logic [9:0] avsAddress, // address
  input wire logic avsRead, // read
  input wire logic avsWrite, // write
  input wire logic [31:0] avsWriteData, // write data
  input wire logic [3:0] avsByteEnable, // lanes
  input wire logic [31:0] avsReadData, // read data
  input wire logic avsWaitRequest, // stall
  input wire logic [1:0] avsResponse, // response
  input wire logic irq // interrupt
);
  localparam logic [9:0] BAD_ADDR = 10'h3FC;
  logic done;
  logic [7:0] modeReg;
  logic [7:0] high0Reg;
  logic [7:0] high1Reg;
  logic [1:0] maskReg;
  // an access completes where waitrequest is sampled low
  assign done = (avsRead | avsWrite) & ~avsWaitRequest;
  // shadow copies of what software wrote
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      modeReg <= 8'h00;
      high0Reg <= 8'h00;
      high1Reg <= 8'h00;
      maskReg <= 2'h0;
    end else if (done && avsWrite) begin
      if (avsAddress == BYTE_MODE && avsByteEnable[0]) modeReg <= avsWriteData[7:0];
      if (avsAddress == BYTE_T0 && avsByteEnable[1]) high0Reg <= avsWriteData[15:8];
      if (avsAddress == BYTE_T1 && avsByteEnable[1]) high1Reg <= avsWriteData[15:8];
      if (avsAddress == BYTE_MASK && avsByteEnable[0]) maskReg <= avsWriteData[1:0];
    end
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  // ==========================================
  // assertions
  chk_wait_first: assert property (($rose(avsRead) || $rose(avsWrite)) |-> avsWaitRequest)
    else $error("request taken without a wait cycle");
  chk_wait_one: assert property ((avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
    else $error("more than one wait cycle");
  chk_idle_ready: assert property (!avsRead && !avsWrite |-> !avsWaitRequest)
    else $error("stall without request");
  chk_data_stands: assert property (!avsRead && !avsWrite |=> $stable(avsReadData) && $stable(avsResponse))
    else $error("read data moved while idle");
  chk_unmapped_err: assert property (done && avsRead && avsAddress == BAD_ADDR |-> avsResponse == 2'h2 && avsReadData == 32'h0)
    else $error("unmapped read not refused");
  chk_mapped_ok: assert property (done && avsAddress == BYTE_MODE |-> avsResponse == 2'h0)
    else $error("mapped access refused");
  chk_mode_back: assert property (done && avsRead && avsAddress == BYTE_MODE |-> avsReadData[7:0] == modeReg)
    else $error("mode readback wrong");
  chk_high0_kept: assert property (done && avsRead && avsAddress == BYTE_T0 &&
    modeReg[MODE_M0_HI:MODE_M0_LO] == MODE_RELOAD |-> avsReadData[15:8] == high0Reg)
    else $error("timer 0 reload byte changed");
  chk_high1_kept: assert property (done && avsRead && avsAddress == BYTE_T1 &&
    modeReg[MODE_M1_HI:MODE_M1_LO] == MODE_RELOAD |-> avsReadData[15:8] == high1Reg)
    else $error("timer 1 reload byte changed");
  chk_irq_masked: assert property (maskReg == 2'h0 |-> !irq)
    else $error("interrupt while masked");
  cov_unmapped: cover property (done && avsAddress == BAD_ADDR);
  cov_irq: cover property ($rose(irq));
  cov_t1_read: cover property (done && avsRead && avsAddress == BYTE_T1);
endmodule : dtm_timer_monitor
bind dtm_timer dtm_timer_monitor u_mon (.mclk(mclk), .reset(reset), .avsAddress(avsAddress), .avsRead(avsRead),
  .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
  .avsWaitRequest(avsWaitRequest), .avsResponse(avsResponse), .irq(irq));
`default_nettype wire

/* sim/dtm_pin_model.sv */
// partner model: gate pins and count pins outside the timer
`timescale 1ns/1ps
`default_nettype none
module dtm_pin_model (
  input wire logic mclk, // clock
  input wire logic [1:0] gateLvl, // gate levels asked for
  input wire logic [1:0] pulseReq, // low pulse asked for
  output var logic ext_irq0_n, // gate pin 0
  output var logic ext_irq1_n, // gate pin 1
  output var logic tmr0_count_pin, // count pin 0
  output var logic tmr1_count_pin // count pin 1
);
  // idle pins sit high
  initial begin
    ext_irq0_n = 1'b1;
    ext_irq1_n = 1'b1;
    tmr0_count_pin = 1'b1;
    tmr1_count_pin = 1'b1;
  end
  // pins move just after the edge
  always @(posedge mclk) begin
    ext_irq0_n <= gateLvl[0];
    ext_irq1_n <= gateLvl[1];
    tmr0_count_pin <= ~pulseReq[0];
    tmr1_count_pin <= ~pulseReq[1];
  end
endmodule : dtm_pin_model
`default_nettype wire

/* sim/dtm_timer_bench.sv */
// testbench: register access, auto-reload overflow, gating and count pin
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_fail++; $display("ERROR %0t got %h want %h", $time, a, e); end end
module dtm_timer_bench
  import dtm_pkg::*;
();
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic clkEn = 1'b1;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [9:0] avsAddress = 10'h000;
  logic [31:0] avsWriteData = 32'h0;
  logic [1:0] gateLvl = 2'h3;
  logic [1:0] pulseReq = 2'h0;
  logic [31:0] avsReadData;
  logic [1:0] avsResponse;
  logic avsWaitRequest, irq, ext_irq0_n, ext_irq1_n, tmr0_count_pin, tmr1_count_pin;
  logic [31:0] q;
  logic [1:0] rsp;
  int n_fail = 0;
  int n_compared = 0;
  // 125 MHz clock
  always #4 mclk = ~mclk;
  dtm_timer uut (.mclk(mclk), .reset(reset), .clkEn(clkEn), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(4'hF), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .avsResponse(avsResponse), .ext_irq0_n(ext_irq0_n),
    .ext_irq1_n(ext_irq1_n), .tmr0_count_pin(tmr0_count_pin), .tmr1_count_pin(tmr1_count_pin), .irq(irq));
  dtm_pin_model u_pins (.mclk(mclk), .gateLvl(gateLvl), .pulseReq(pulseReq), .ext_irq0_n(ext_irq0_n),
    .ext_irq1_n(ext_irq1_n), .tmr0_count_pin(tmr0_count_pin), .tmr1_count_pin(tmr1_count_pin));
  // counts and verdict, then stop
  task automatic final_report();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  // one bus access, held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avsAddress <= a;
    avsWriteData <= d;
    avsWrite <= wr;
    avsRead <= ~wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avsWaitRequest !== 1'b0 && n < 50);
    `CHK(avsWaitRequest, 1'b0)
    if (avsWaitRequest !== 1'b0) final_report();
    q = avsReadData;
    rsp = avsResponse;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge mclk);
  endtask : xfer
  // bounded wait for the interrupt line
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 300) begin
      @(posedge mclk);
      n++;
    end
    `CHK(irq, 1'b1)
    if (irq !== 1'b1) final_report();
  endtask : wait_irq
  // one falling edge on the count pins
  task automatic pulse();
    repeat (4) @(posedge mclk);
    pulseReq <= 2'h3;
    repeat (4) @(posedge mclk);
    pulseReq <= 2'h0;
    repeat (8) @(posedge mclk);
  endtask : pulse
  // mode codes read back, unmapped address refused
  task automatic test_regs();
    xfer(0, BYTE_MODE, 32'h0);
    `CHK(q[7:0], MODE_RESET)
    for (int m = 0; m < 4; m++) begin
      xfer(1, BYTE_MODE, 32'(m * 17));
      xfer(0, BYTE_MODE, 32'h0);
      `CHK(q[7:0], 8'(m * 17))
    end
    xfer(1, 10'h3FC, 32'hFFFF_FFFF);
    xfer(0, 10'h3FC, 32'h0);
    `CHK({rsp, q}, {2'h2, 32'h0})
  endtask : test_regs
  // timer 0 auto-reload on the fast clock
  task automatic test_t0_reload();
    xfer(1, BYTE_MODE, 32'h02);
    xfer(1, BYTE_CLK, 32'h04);
    xfer(1, BYTE_MASK, 32'h01);
    xfer(1, BYTE_T0, 32'hF0FD);
    xfer(1, BYTE_CTRL, 32'h10);
    wait_irq();
    xfer(0, BYTE_CTRL, 32'h0);
    `CHK(q[5], 1'b1)
    xfer(1, BYTE_CTRL, 32'h20);
    xfer(0, BYTE_T0, 32'h0);
    `CHK(q[15:8], 8'hF0)
    `CHK(q[7:0] >= 8'hF0, 1'b1)
    xfer(0, BYTE_STAT, 32'h0);
    `CHK(q[1:0], 2'h1)
    xfer(1, BYTE_STAT, 32'h1);
    xfer(1, BYTE_CTRL, 32'h0);
    `CHK(irq, 1'b0)
  endtask : test_t0_reload
  // timer 1 held by its gate pin, then released
  task automatic test_t1_gate();
    xfer(1, BYTE_MODE, 32'hA0);
    xfer(1, BYTE_CLK, 32'h08);
    xfer(1, BYTE_IRQCFG, 32'h0);
    xfer(1, BYTE_MASK, 32'h02);
    xfer(1, BYTE_T1, 32'h80FE);
    xfer(1, BYTE_CTRL, 32'h40);
    repeat (20) @(posedge mclk);
    xfer(0, BYTE_T1, 32'h0);
    `CHK(q[15:0], 16'h80FE)
    gateLvl <= 2'h1;
    wait_irq();
    xfer(0, BYTE_STAT, 32'h0);
    `CHK(q[1:0], 2'h2)
    xfer(0, BYTE_CTRL, 32'h0);
    `CHK(q[7], 1'b1)
    xfer(1, BYTE_CTRL, 32'h0);
    xfer(1, BYTE_STAT, 32'h3);
  endtask : test_t1_gate
  // timer 0 counting pin edges under its gate
  task automatic test_t0_pin();
    xfer(1, BYTE_MODE, 32'h0E);
    xfer(1, BYTE_IRQCFG, 32'h08);
    gateLvl <= 2'h2;
    xfer(1, BYTE_T0, 32'h40FE);
    xfer(1, BYTE_CTRL, 32'h10);
    pulse();
    xfer(0, BYTE_T0, 32'h0);
    `CHK(q[15:0], 16'h40FE)
    gateLvl <= 2'h3;
    pulse();
    pulse();
    xfer(0, BYTE_T0, 32'h0);
    `CHK(q[7:0], 8'h40)
    xfer(0, BYTE_CTRL, 32'h0);
    `CHK(q[5], 1'b1)
  endtask : test_t0_pin
  // 13-bit timer 0, stopped timer 1, 16-bit timer 0, then clock enable held low
  task automatic test_modes();
    logic [15:0] first;
    xfer(1, BYTE_CLK, 32'h0C);
    xfer(1, BYTE_MASK, 32'h01);
    xfer(1, BYTE_MODE, 32'h30);
    xfer(1, BYTE_T0, 32'hFF0F);
    xfer(1, BYTE_T1, 32'h0);
    xfer(1, BYTE_CTRL, 32'h50);
    xfer(0, BYTE_T0, 32'h0);
    `CHK(q[15:4], 12'hFF1)
    wait_irq();
    xfer(0, BYTE_T1, 32'h0);
    `CHK(q[15:0], 16'h0000)
    xfer(1, BYTE_CTRL, 32'h0);
    xfer(1, BYTE_STAT, 32'h3);
    xfer(1, BYTE_MODE, 32'h01);
    xfer(1, BYTE_T0, 32'hFFFE);
    xfer(1, BYTE_CTRL, 32'h10);
    wait_irq();
    xfer(0, BYTE_T0, 32'h0);
    `CHK(q[15:8], 8'h00)
    first = q[15:0];
    clkEn <= 1'b0;
    repeat (100) @(posedge mclk);
    clkEn <= 1'b1;
    xfer(0, BYTE_T0, 32'h0);
    `CHK(q[15:0] - first < 16'd8 && q[15:0] != first, 1'b1)
    xfer(1, BYTE_CTRL, 32'h0);
    xfer(1, BYTE_STAT, 32'h3);
  endtask : test_modes
  // main sequence
  initial begin
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    test_regs();
    test_t0_reload();
    test_t1_gate();
    test_modes();
    test_t0_pin();
    final_report();
  end
endmodule : dtm_timer_bench
`default_nettype wire
